// [rtl/uogs_pkg.sv]
package uogs_pkg;

  // byte addresses of the register words
  localparam logic [11:0] UOGS_CTRL_OFF   = 12'h800;
  localparam logic [11:0] UOGS_STATUS_OFF = 12'h804;
  localparam logic [11:0] UOGS_CLEAR_OFF  = 12'h808;
  localparam logic [11:0] UOGS_SET_OFF    = 12'h80c;

  // status word fields
  localparam int UOGS_CLK_OK_BIT   = 14;
  localparam int UOGS_SPEED_LSB    = 12;
  localparam int UOGS_VBUS_BIT     = 11;
  localparam int UOGS_ID_BIT       = 10;
  localparam int UOGS_VBUS_REQ_BIT = 9;
  localparam int UOGS_SUSP_TO_BIT  = 7;
  localparam int UOGS_ROLE_BIT     = 5;
  localparam int UOGS_BCERR_BIT    = 4;
  localparam int UOGS_VBERR_BIT    = 3;
  localparam int UOGS_VBUST_BIT    = 1;
  localparam int UOGS_IDT_BIT      = 0;

  // control word fields; enables share the flag positions
  localparam int UOGS_CTRL_EN_BIT  = 15;
  localparam int UOGS_HWC_OFF_BIT  = 8;

  localparam logic [7:0]  UOGS_FLAG_MASK   = 8'hbb;
  localparam logic [15:0] UOGS_CTRL_MASK   = 16'h81bb;
  localparam logic [15:0] UOGS_CTRL_RESET  = 16'h0000;
  localparam logic [7:0]  UOGS_FLAG_RESET  = 8'h00;
  localparam logic [2:0]  UOGS_SYNC_RESET  = 3'h0;
  localparam logic [2:0]  UOGS_ID_SYNC_RST = 3'h7;
  localparam logic        UOGS_ID_LVL_RST  = 1'b1;

  localparam logic [1:0] UOGS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UOGS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } uogs_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } uogs_axi_rsp_s;

  typedef struct packed {
    logic [2:0]  clk_sync;
    logic [2:0]  vbus_sync;
    logic [2:0]  id_sync;
    logic        clk_ok;
    logic        vbus_lvl;
    logic        id_lvl;
    logic [15:0] ctrl;
    logic [7:0]  flags;
    logic        vbus_req;
    logic        aw_got;
    logic        w_got;
    logic [11:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uogs_state_s;

endpackage

// [rtl/uogs_top.sv]
`timescale 1ns/1ns
module uogs_top
  import uogs_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  input  wire uogs_axi_req_s axi_req_i,
  output uogs_axi_rsp_s      axi_rsp_o,
  input  wire logic          utmi_clock_ok_i,
  input  wire logic [1:0]    speed_i,
  input  wire logic          vbus_i,
  input  wire logic          otg_id_input_i,
  input  wire logic          suspend_timeout_evt_i,
  input  wire logic          role_swap_evt_i,
  input  wire logic          b_connect_error_evt_i,
  input  wire logic          vbus_error_evt_i,
  output logic               vbus_supply_control_out_o,
  output logic               controller_enable_o,
  output logic               usb_irq_o
);

  uogs_state_s st;
  uogs_state_s next_st;

  logic [31:0] status_word;
  logic [31:0] byte_mask;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        wr_do;
  logic [11:0] wr_addr;
  logic [11:0] rd_addr;
  logic [31:0] wr_bits;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic        req_set;
  logic        req_clr;
  logic        rd_hit;
  logic [31:0] rd_word;

  always_comb begin
    status_word = 32'h0;
    status_word[UOGS_CLK_OK_BIT] = st.clk_ok;
    status_word[UOGS_SPEED_LSB +: 2] = speed_i;
    status_word[UOGS_VBUS_BIT] = st.vbus_lvl;
    status_word[UOGS_ID_BIT] = st.id_lvl;
    status_word[UOGS_VBUS_REQ_BIT] = st.vbus_req;
    status_word[7:0] = st.flags;
  end

  assign axi_rsp_o.awready = !st.aw_got && !st.bvalid;
  assign axi_rsp_o.wready  = !st.w_got && !st.bvalid;
  assign axi_rsp_o.bvalid  = st.bvalid;
  assign axi_rsp_o.bresp   = st.bresp;
  assign axi_rsp_o.arready = !st.rvalid;
  assign axi_rsp_o.rvalid  = st.rvalid;
  assign axi_rsp_o.rdata   = st.rdata;
  assign axi_rsp_o.rresp   = st.rresp;

  assign vbus_supply_control_out_o = st.vbus_req;
  assign controller_enable_o = st.ctrl[UOGS_CTRL_EN_BIT];
  assign usb_irq_o = |(st.flags & st.ctrl[7:0] & UOGS_FLAG_MASK);

  always_comb begin
    next_st = st;
    aw_take = axi_req_i.awvalid && axi_rsp_o.awready;
    w_take  = axi_req_i.wvalid && axi_rsp_o.wready;
    ar_take = axi_req_i.arvalid && axi_rsp_o.arready;

    // only agreeing later stages count; stage one feeds stage two alone
    next_st.clk_sync  = {st.clk_sync[1:0], utmi_clock_ok_i};
    next_st.vbus_sync = {st.vbus_sync[1:0], vbus_i};
    next_st.id_sync   = {st.id_sync[1:0], otg_id_input_i};
    if (st.clk_sync[1] == st.clk_sync[2]) begin
      next_st.clk_ok = st.clk_sync[2];
    end
    if (st.vbus_sync[1] == st.vbus_sync[2]) begin
      next_st.vbus_lvl = st.vbus_sync[2];
    end
    // id path has no dependence on controller enable
    if (st.id_sync[1] == st.id_sync[2]) begin
      next_st.id_lvl = st.id_sync[2];
    end

    // write channel: address and data taken in either order
    if (aw_take) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = axi_req_i.awaddr[11:0];
    end
    if (w_take) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req_i.wdata;
      next_st.wstrb = axi_req_i.wstrb;
    end
    wr_do   = st.aw_got && st.w_got && !st.bvalid;
    wr_addr = {st.aw_addr[11:2], 2'h0};
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{st.wstrb[i]}};
    end
    wr_bits = st.wdata & byte_mask;

    flag_set = 8'h0;
    flag_clr = 8'h0;
    req_set  = 1'b0;
    req_clr  = 1'b0;
    if (wr_do) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = UOGS_RESP_OKAY;
      unique case (wr_addr)
        UOGS_CTRL_OFF: begin
          next_st.ctrl = (st.ctrl & ~byte_mask[15:0])
                       | (wr_bits[15:0] & UOGS_CTRL_MASK);
        end
        UOGS_STATUS_OFF: begin
          next_st.bresp = UOGS_RESP_OKAY;
        end
        UOGS_CLEAR_OFF: begin
          flag_clr = wr_bits[7:0] & UOGS_FLAG_MASK;
          req_clr  = wr_bits[UOGS_VBUS_REQ_BIT];
        end
        UOGS_SET_OFF: begin
          flag_set = wr_bits[7:0] & UOGS_FLAG_MASK;
          req_set  = wr_bits[UOGS_VBUS_REQ_BIT];
        end
        default: begin
          next_st.bresp = UOGS_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && axi_req_i.bready) begin
      next_st.bvalid = 1'b0;
    end

    // hardware events
    flag_set[UOGS_SUSP_TO_BIT] = flag_set[UOGS_SUSP_TO_BIT]
                               | suspend_timeout_evt_i;
    flag_set[UOGS_ROLE_BIT] = flag_set[UOGS_ROLE_BIT]
                            | role_swap_evt_i;
    flag_set[UOGS_BCERR_BIT] = flag_set[UOGS_BCERR_BIT]
                             | b_connect_error_evt_i;
    // set regardless of the hardware control bit
    flag_set[UOGS_VBERR_BIT] = flag_set[UOGS_VBERR_BIT]
                             | vbus_error_evt_i;
    flag_set[UOGS_VBUST_BIT] = flag_set[UOGS_VBUST_BIT]
                             | (st.vbus_lvl != next_st.vbus_lvl);
    flag_set[UOGS_IDT_BIT] = flag_set[UOGS_IDT_BIT]
                           | (st.id_lvl != next_st.id_lvl);
    if (vbus_error_evt_i && !st.ctrl[UOGS_HWC_OFF_BIT]) begin
      req_clr = 1'b1;
    end
    // a set arriving with its clear is kept
    next_st.flags = (st.flags & ~flag_clr) | flag_set;
    next_st.vbus_req = (st.vbus_req && !req_clr) || req_set;

    // read channel: one cycle to answer
    rd_addr = {axi_req_i.araddr[11:2], 2'h0};
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    unique case (rd_addr)
      UOGS_CTRL_OFF:   rd_word = {16'h0, st.ctrl};
      UOGS_STATUS_OFF: rd_word = status_word;
      UOGS_CLEAR_OFF:  rd_word = 32'h0;
      UOGS_SET_OFF:    rd_word = 32'h0;
      default:         rd_hit  = 1'b0;
    endcase
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_hit ? UOGS_RESP_OKAY : UOGS_RESP_SLVERR;
    end else if (st.rvalid && axi_req_i.rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st           <= '0;
      st.clk_sync  <= UOGS_SYNC_RESET;
      st.vbus_sync <= UOGS_SYNC_RESET;
      st.id_sync   <= UOGS_ID_SYNC_RST;
      st.id_lvl    <= UOGS_ID_LVL_RST;
      st.ctrl      <= UOGS_CTRL_RESET;
      st.flags     <= UOGS_FLAG_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [bench/uogs_assertions.sv]
`timescale 1ns/1ns
module uogs_chk
  import uogs_pkg::*;
(
  input wire logic          clk_sys_i,
  input wire logic          reset_i,
  input wire uogs_axi_req_s axi_req_i,
  input wire uogs_axi_rsp_s axi_rsp_o,
  input wire logic          otg_id_input_i,
  input wire logic          vbus_i,
  input wire logic          suspend_timeout_evt_i,
  input wire logic          role_swap_evt_i,
  input wire logic          b_connect_error_evt_i,
  input wire logic          vbus_error_evt_i,
  input wire logic          vbus_supply_control_out_o,
  input wire logic          usb_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire logic evt = suspend_timeout_evt_i | role_swap_evt_i |
                   b_connect_error_evt_i | vbus_error_evt_i;
  sequence s_st_rd;
    axi_req_i.arvalid && axi_rsp_o.arready &&
      axi_req_i.araddr[11:2] == UOGS_STATUS_OFF[11:2];
  endsequence
  // six calm cycles outlast the three-flop synchroniser
  property p_id;
    $stable(otg_id_input_i)[*6] ##0 s_st_rd |=>
      axi_rsp_o.rdata[UOGS_ID_BIT] == $past(otg_id_input_i);
  endproperty
  property p_vbus;
    $stable(vbus_i)[*6] ##0 s_st_rd |=>
      axi_rsp_o.rdata[UOGS_VBUS_BIT] == $past(vbus_i);
  endproperty
  property p_b_hold;
    axi_rsp_o.bvalid && !axi_req_i.bready |=>
      axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
  endproperty
  property p_r_hold;
    axi_rsp_o.rvalid && !axi_req_i.rready |=>
      axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata);
  endproperty
  property p_r_lat;
    axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid;
  endproperty
  property p_busy;
    axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
  endproperty
  property p_irq;
    $rose(usb_irq_o) |-> $past(evt) || $rose(axi_rsp_o.bvalid);
  endproperty
  property p_sup;
    $changed(vbus_supply_control_out_o) |->
      $rose(axi_rsp_o.bvalid) || $past(vbus_error_evt_i);
  endproperty
  a_id: assert property (p_id) else $error("id bit wrong");
  a_vbus: assert property (p_vbus) else $error("vbus bit wrong");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_busy: assert property (p_busy) else $error("write taken busy");
  a_irq: assert property (p_irq) else $error("irq no cause");
  a_sup: assert property (p_sup) else $error("supply no cause");
endmodule
bind uogs_top uogs_chk u_chk (.*);

// [bench/uogs_far.sv]
`timescale 1ns/1ns
module uogs_far (
  input  wire logic clk_sys_i,
  input  wire logic supply_i,
  input  wire logic cable_i,
  input  wire logic id_i,
  output logic      vbus_o,
  output logic      id_o
);
  // the line takes a few cycles to charge once the switch closes
  logic [3:0] ramp = 4'h0;
  always @(posedge clk_sys_i) ramp <= {ramp[2:0], supply_i & cable_i};
  assign vbus_o = ramp[3];
  // id pin is pulled up while nothing is plugged in
  assign id_o = cable_i ? id_i : 1'b1;
endmodule

// [bench/tb.sv]
`timescale 1ns/1ns
module tb
  import uogs_pkg::*;
;
  typedef struct packed {logic [31:0] w; logic [31:0] e;} uogs_row_s;
  uogs_row_s     rows [5] = '{'{32'h80, 32'h80}, '{32'h30, 32'h30},
                              '{32'h8, 32'h8}, '{32'h200, 32'h200},
                              '{32'h4, 32'h0}};
  logic [31:0]   fb [4] = '{32'h8, 32'h10, 32'h20, 32'h80};
  logic          clk_sys_i = 0, reset_i = 1, clk_ok = 0, cable = 0, idp = 1;
  logic [1:0]    spd = 2'h0, r;
  logic [3:0]    ev = 4'h0;
  logic [31:0]   d;
  uogs_axi_req_s rq = '0;
  uogs_axi_rsp_s rs;
  logic          vb, idw, sup, irq, en, lag = 1'b0;
  int            errors = 0, checks = 0;
  uogs_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .axi_req_i(rq),
    .axi_rsp_o(rs), .utmi_clock_ok_i(clk_ok), .speed_i(spd), .vbus_i(vb),
    .otg_id_input_i(idw), .suspend_timeout_evt_i(ev[3]),
    .role_swap_evt_i(ev[2]), .b_connect_error_evt_i(ev[1]),
    .vbus_error_evt_i(ev[0]), .vbus_supply_control_out_o(sup),
    .controller_enable_o(en), .usb_irq_o(irq));
  uogs_far far (.clk_sys_i(clk_sys_i), .supply_i(sup), .cable_i(cable),
    .id_i(idp), .vbus_o(vb), .id_o(idw));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task complete_run;
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // lag holds back bready and rready one cycle so the slave must wait
  task wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    logic aw, w, b, bv;
    @(posedge clk_sys_i);
    rq.awaddr <= {20'h0, a};
    rq.wdata <= v;
    rq.wstrb <= 4'hf;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= !lag;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_sys_i);
      aw = rq.awvalid & rs.awready;
      w = rq.wvalid & rs.wready;
      b = rs.bvalid & rq.bready;
      bv = rs.bvalid;
      r = rs.bresp;
      @(posedge clk_sys_i);
      if (aw) rq.awvalid <= 1'b0;
      if (w) rq.wvalid <= 1'b0;
      if (b) break;
      if (bv) rq.bready <= 1'b1;
    end
    rq.bready <= 1'b0;
    if (n == 40) begin
      errors++;
      complete_run();
    end
  endtask
  task rd(input logic [11:0] a);
    int n;
    logic ar, v, rv;
    @(posedge clk_sys_i);
    rq.araddr <= {20'h0, a};
    rq.arvalid <= 1'b1;
    rq.rready <= !lag;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_sys_i);
      ar = rq.arvalid & rs.arready;
      v = rs.rvalid & rq.rready;
      rv = rs.rvalid;
      d = rs.rdata;
      @(posedge clk_sys_i);
      if (ar) rq.arvalid <= 1'b0;
      if (v) break;
      if (rv) rq.rready <= 1'b1;
    end
    rq.rready <= 1'b0;
    if (n == 40) begin
      errors++;
      complete_run();
    end
  endtask
  task pulse(input int i);
    @(posedge clk_sys_i);
    ev[i] <= 1'b1;
    @(posedge clk_sys_i);
    ev[i] <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(UOGS_STATUS_OFF); chk("status", d, 32'h400);
    foreach (rows[i]) begin
      wr(UOGS_SET_OFF, rows[i].w);
      rd(UOGS_STATUS_OFF); chk("set", d & 32'h2bb, rows[i].e);
      chk("supply", 32'(sup), 32'(rows[i].e[9]));
      wr(UOGS_CLEAR_OFF, rows[i].w);
      rd(UOGS_STATUS_OFF); chk("clr", d & 32'h2bb, 0);
    end
    for (int i = 0; i < 4; i++) begin
      pulse(i); chk("masked", 32'(irq), 0);
      wr(UOGS_CTRL_OFF, fb[i]);
      @(negedge clk_sys_i); chk("irq", 32'(irq), 1);
      rd(UOGS_STATUS_OFF); chk("flag", d & 32'hbb, fb[i]);
      wr(UOGS_CLEAR_OFF, fb[i]);
      @(negedge clk_sys_i); chk("irq clr", 32'(irq), 0);
    end
    wr(UOGS_SET_OFF, 32'h200);
    pulse(0); chk("hw off", 32'(sup), 0);
    wr(UOGS_CTRL_OFF, 32'h100);
    wr(UOGS_CLEAR_OFF, 32'h8);
    wr(UOGS_SET_OFF, 32'h200);
    pulse(0); chk("hw kept", 32'(sup), 1);
    wr(UOGS_STATUS_OFF, 32'hffff_ffff); chk("resp", 32'(r), 0);
    rd(UOGS_STATUS_OFF); chk("ro", d, 32'h608);
    wr(12'h900, 0); chk("unmapped", 32'(r), 32'(UOGS_RESP_SLVERR));
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys_i);
      {cable, idp, clk_ok, spd} <= {3'b101, 2'(s)};
      repeat (8) @(posedge clk_sys_i);
      rd(UOGS_STATUS_OFF);
      chk("pins", d & 32'h7c00, 32'h4800 | s << 12);
    end
    lag = 1'b1;
    wr(UOGS_CTRL_OFF, 32'h8000);
    chk("enable", 32'(en), 32'h1);
    rd(UOGS_CTRL_OFF);
    chk("ctrl", d, 32'h8000);
    rd(UOGS_SET_OFF);
    chk("set read", d, 32'h0);
    lag = 1'b0;
    // mid-run reset with the power request and enable both up
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("rst supply", 32'(sup), 32'h0);
    chk("rst enable", 32'(en), 32'h0);
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(UOGS_STATUS_OFF);
    chk("rst status", d, 32'h3400);
    rd(UOGS_CTRL_OFF);
    chk("rst ctrl", d, 32'h0);
    repeat (8) @(posedge clk_sys_i);
    rd(UOGS_STATUS_OFF);
    chk("settled", d & 32'h7ffd, 32'h7001);
    complete_run();
  end
endmodule
